// ### rtl/smi_inval_map.sv
// invalidation map and invalidate broadcaster for a shared memory
// assumes completed reads/writes arrive one per cycle as pulses
`timescale 1ns/1ps
`include "smi_consts.svh"
// Function
// (R1) any completed write broadcasts invalidate address
// (R2) processors drop matching cache lines
// (R3) invalidated line misses, refetches shared memory
// (R4) map holds four presence bits per quadword
// (R5) quadword read sets reader's presence bit; code drops it if a write to another quadword completes in the same cycle
// (R6) selective mode notifies only marked processors
// (R7) after notify, keep only writer's bit; code also keeps a same-cycle reader of that quadword
// (R8) map cleared at initialization
module smi_inval_map #(
   parameter int NPORT = `SMI_NUM_PORTS,
   parameter int QW_W = `SMI_QW_ADDR_W
) (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic CE,
   input wire logic SELECTIVE,
   input wire logic RD_DONE,
   input wire logic [1:0] RD_PORT,
   input wire logic [QW_W-1:0] RD_QW,
   input wire logic WR_DONE,
   input wire logic [1:0] WR_PORT,
   input wire logic [QW_W-1:0] WR_QW,
   output logic ACC_READY,
   output logic INIT_DONE,
   output logic INV_VALID,
   output logic [NPORT-1:0] INV_TARGET,
   output logic [QW_W+2:0] INV_ADDR
);
   localparam int DEPTH = 1 << QW_W;
   // one presence bit per processor per quadword
   logic [NPORT-1:0] map_mem [DEPTH]; // see (R4)
   smi_pkg::smi_state_t state, next_state;
   logic [QW_W-1:0] clr_idx, next_clr_idx;
   logic [NPORT-1:0] rd_mask, wr_mask;
   logic map_we;
   logic [QW_W-1:0] map_idx;
   logic [NPORT-1:0] map_wdata;
   logic next_inv_valid;
   logic [NPORT-1:0] next_inv_target;
   logic [QW_W+2:0] next_inv_addr;

   assign rd_mask = NPORT'(1) << RD_PORT;
   assign wr_mask = NPORT'(1) << WR_PORT;
   // accesses are held off while the map is being wiped
   assign ACC_READY = (state != smi_pkg::SMI_CLEAR);
   assign INIT_DONE = (state != smi_pkg::SMI_CLEAR);

   always_comb begin
      next_state = state;
      next_clr_idx = clr_idx;
      map_we = 1'b0;
      map_idx = clr_idx;
      map_wdata = `SMI_MAP_RESET;
      next_inv_valid = 1'b0;
      next_inv_target = INV_TARGET;
      next_inv_addr = INV_ADDR;
      case (state)
         smi_pkg::SMI_CLEAR: begin
            map_we = 1'b1; // see (R8)
            next_clr_idx = clr_idx + QW_W'(1);
            if (clr_idx == QW_W'(DEPTH - 1)) begin
               next_state = smi_pkg::SMI_IDLE;
            end
         end
         smi_pkg::SMI_IDLE, smi_pkg::SMI_NOTIFY: begin
            next_state = smi_pkg::SMI_IDLE;
            if (WR_DONE) begin
               next_state = smi_pkg::SMI_NOTIFY;
               next_inv_valid = 1'b1; // see (R1)
               next_inv_addr = {WR_QW, 3'h0};
               // basic mode tells everybody; selective uses the map
               next_inv_target = SELECTIVE ? map_mem[WR_QW]
                                           : {NPORT{1'b1}}; // see (R6)
               map_we = 1'b1;
               map_idx = WR_QW;
               // writer's own line stays valid; the rest are stale
               map_wdata = map_mem[WR_QW] & wr_mask; // see (R7)
               if (RD_DONE && RD_QW == WR_QW) begin
                  map_wdata = map_wdata | rd_mask;
               end
            end else if (RD_DONE) begin
               map_we = 1'b1;
               map_idx = RD_QW;
               map_wdata = map_mem[RD_QW] | rd_mask; // see (R5)
            end
         end
         default: begin
            next_state = smi_pkg::SMI_CLEAR;
            next_clr_idx = '0;
         end
      endcase
   end

   // limitation: a read and write to different quadwords in one
   // cycle drops the read mark; the controller serialises ports
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         state <= smi_pkg::SMI_CLEAR;
         clr_idx <= '0;
         INV_VALID <= 1'b0;
         INV_TARGET <= '0;
         INV_ADDR <= '0;
      end else if (CE) begin
         state <= next_state;
         clr_idx <= next_clr_idx;
         INV_VALID <= next_inv_valid;
         INV_TARGET <= next_inv_target;
         INV_ADDR <= next_inv_addr;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (CE && map_we && !RST) begin
         map_mem[map_idx] <= map_wdata;
      end
   end

   property p_wr_inval;
      @(posedge CLOCK) disable iff (RST)
      (CE && WR_DONE && state != smi_pkg::SMI_CLEAR) |=>
         INV_VALID && INV_ADDR == {$past(WR_QW), 3'h0};
   endproperty
   a_wr_inval: assert property (p_wr_inval) // see (R1)
      else $error("write produced no invalidate");

   property p_basic_all;
      @(posedge CLOCK) disable iff (RST)
      (CE && WR_DONE && !SELECTIVE && state != smi_pkg::SMI_CLEAR)
         |=> INV_TARGET == {NPORT{1'b1}};
   endproperty
   a_basic_all: assert property (p_basic_all) // see (R6)
      else $error("basic mode missed a processor");

   property p_no_spurious;
      @(posedge CLOCK) disable iff (RST)
      (CE && !WR_DONE) |=> !INV_VALID;
   endproperty
   a_no_spurious: assert property (p_no_spurious) // see (R1)
      else $error("invalidate without write");

   // one idle cycle between the read and the write, as masters issue them
   sequence s_read_then_write;
      CE && RD_DONE && !WR_DONE && state == smi_pkg::SMI_IDLE
         ##1 !WR_DONE
         ##1 CE && WR_DONE && !RD_DONE && SELECTIVE
         && WR_QW == $past(RD_QW, 2);
   endsequence
   property p_reader_told;
      @(posedge CLOCK) disable iff (RST)
      s_read_then_write |=> INV_TARGET[$past(RD_PORT, 3)];
   endproperty
   a_reader_told: assert property (p_reader_told) // see (R5)
      else $error("reader not notified");

   sequence s_write_then_write;
      CE && WR_DONE && !RD_DONE && SELECTIVE
         && state != smi_pkg::SMI_CLEAR
         ##1 !WR_DONE && !RD_DONE
         ##1 CE && WR_DONE && !RD_DONE && SELECTIVE
         && WR_QW == $past(WR_QW, 2);
   endsequence
   property p_keep_writer;
      @(posedge CLOCK) disable iff (RST)
      s_write_then_write |=>
         (INV_TARGET & ~(NPORT'(1) << $past(WR_PORT, 3))) == '0;
   endproperty
   a_keep_writer: assert property (p_keep_writer) // see (R7)
      else $error("non-writer bits survived a write");

   property p_init_clear;
      @(posedge CLOCK) disable iff (RST)
      (state == smi_pkg::SMI_CLEAR) |-> !INV_VALID && !ACC_READY;
   endproperty
   a_init_clear: assert property (p_init_clear) // see (R8)
      else $error("activity during map wipe");

   // a lone read must leave the reader marked
   property p_read_mark;
      @(posedge CLOCK) disable iff (RST)
      (CE && RD_DONE && !WR_DONE && ACC_READY) |=>
         map_mem[$past(RD_QW)][$past(RD_PORT)];
   endproperty
   a_read_mark: assert property (p_read_mark) // see (R5)
      else $error("read left no presence bit");

   sequence s_quiet_write;
      CE && WR_DONE && !RD_DONE && ACC_READY;
   endsequence
   // entry after a write keeps at most the writer's bit
   property p_map_trim;
      @(posedge CLOCK) disable iff (RST)
      s_quiet_write |=> map_mem[$past(WR_QW)] ==
         ($past(map_mem[WR_QW]) & (NPORT'(1) << $past(WR_PORT)));
   endproperty
   a_map_trim: assert property (p_map_trim) // see (R7)
      else $error("map entry not trimmed to writer");

   property p_sel_target;
      @(posedge CLOCK) disable iff (RST)
      (CE && WR_DONE && SELECTIVE && ACC_READY) |=>
         INV_TARGET == $past(map_mem[WR_QW]);
   endproperty
   a_sel_target: assert property (p_sel_target) // see (R6)
      else $error("selective targets differ from map entry");

   property p_wipe_zero;
      @(posedge CLOCK) disable iff (RST)
      (CE && state == smi_pkg::SMI_CLEAR) |=>
         map_mem[$past(clr_idx)] == '0;
   endproperty
   a_wipe_zero: assert property (p_wipe_zero) // see (R8)
      else $error("wiped entry not zero");

   // processors match on quadword, so low byte bits stay zero
   property p_addr_aligned;
      @(posedge CLOCK) disable iff (RST)
      INV_VALID |-> INV_ADDR[2:0] == 3'h0;
   endproperty
   a_addr_aligned: assert property (p_addr_aligned) // see (R1)
      else $error("invalidate address not quadword aligned");
endmodule // smi_inval_map

// ### rtl/smi_consts.svh
// constants for the shared memory invalidation map
// assumes inclusion by the map module and its package
`ifndef SMI_CONSTS_SVH
`define SMI_CONSTS_SVH
`define SMI_NUM_PORTS 4
`define SMI_QW_ADDR_W 20
`define SMI_ADDR_W 23
`define SMI_QW_SHIFT 3
`define SMI_MAP_RESET 4'h0
`endif

// ### rtl/smi_pkg.sv
// types for the shared memory invalidation map
// assumes smi_consts.svh is on the include path
`include "smi_consts.svh"
package smi_pkg;
   typedef enum logic [1:0] {
      SMI_CLEAR = 2'b00,
      SMI_IDLE = 2'b01,
      SMI_NOTIFY = 2'b10
   } smi_state_t;
endpackage

// ### tb/smi_cache_model.sv
// four processor caches, one line each, facing the invalidate output
// assumes invalidates arrive as one-cycle pulses on the block's clock
`timescale 1ns/1ps
module smi_cache_model (
   input wire logic clk,
   input wire logic fill,
   input wire logic [1:0] fill_port,
   input wire logic [3:0] fill_qw,
   input wire logic inv,
   input wire logic [3:0] inv_tgt,
   input wire logic [6:0] inv_addr,
   output logic [3:0] line_ok
);
   logic [3:0] tag [4];
   initial line_ok = 4'h0;
   always @(posedge clk) begin
      for (int p = 0; p < 4; p++) begin
         if (inv && inv_tgt[p] && tag[p] == inv_addr[6:3]) begin
            line_ok[p] <= 1'b0;
         end
      end
      if (fill) begin
         tag[fill_port] <= fill_qw;
         line_ok[fill_port] <= 1'b1;
      end
   end
endmodule // smi_cache_model

// ### tb/shared_memory_invalidation_map_bench.sv
// self-checking bench for the invalidation map
// assumes a 16-quadword map so the wipe stays short
`timescale 1ns/1ps
module shared_memory_invalidation_map_bench;
   logic clk = 0, rst = 1, sel = 1, rdv = 0, wrv = 0;
   logic [1:0] rp = 0, wp = 0;
   logic [3:0] rq = 0, wq = 0, tgt, ok;
   logic [6:0] addr;
   logic inv, rdy, done;
   int err_total = 0;
   int checked = 0;
   smi_inval_map #(.QW_W(4)) uut (.CLOCK(clk), .RST(rst), .CE(1'b1),
      .SELECTIVE(sel), .RD_DONE(rdv), .RD_PORT(rp), .RD_QW(rq),
      .WR_DONE(wrv), .WR_PORT(wp), .WR_QW(wq), .ACC_READY(rdy),
      .INIT_DONE(done), .INV_VALID(inv), .INV_TARGET(tgt),
      .INV_ADDR(addr));
   smi_cache_model cm (.clk(clk), .fill(rdv), .fill_port(rp),
      .fill_qw(rq), .inv(inv), .inv_tgt(tgt), .inv_addr(addr),
      .line_ok(ok));
   initial forever #2.5 clk = ~clk;
   task chk(input logic [7:0] s, input logic [7:0] e);
      checked++;
      if (s !== e) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task rd(input logic [1:0] p, input logic [3:0] q);
      @(posedge clk);
      rdv <= 1;
      rp <= p;
      rq <= q;
      @(posedge clk);
      rdv <= 0;
   endtask
   task wr(input logic [1:0] p, input logic [3:0] q, input logic [3:0] e);
      @(posedge clk);
      wrv <= 1;
      wp <= p;
      wq <= q;
      @(posedge clk);
      wrv <= 0;
      #1;
      chk(inv, 8'h01);
      chk(tgt, e);
      chk(addr, {q, 3'h0});
   endtask
   task summarize;
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #5000;
      err_total++;
      summarize;
   end
   initial begin
      repeat (12) @(posedge clk);
      rst <= 0;
      for (int i = 0; i < 40 && rdy !== 1'b1; i++) @(posedge clk);
      chk(done, 8'h01);
      wr(0, 3, 4'h0);
      $display("init test ended");
      rd(1, 5);
      rd(3, 5);
      wr(2, 5, 4'ha);
      @(posedge clk);
      #1;
      chk(ok, 8'h00);
      wr(0, 5, 4'h0);
      $display("selective test ended");
      rd(0, 7);
      wr(0, 7, 4'h1);
      wr(1, 7, 4'h1);
      $display("writer bit test ended");
      @(posedge clk);
      sel <= 0;
      wr(2, 9, 4'hf);
      $display("broadcast test ended");
      summarize;
   end
endmodule // shared_memory_invalidation_map_bench
